// ---- src/clock_source_ctrl_trim_status.sv ----
// Clock source divider, oscillator control, trim and status with AHB-Lite.
`include "clk_src_defs.svh"
module clock_source_ctrl_trim_status
  import clk_src_pkg::*;
#(
  parameter logic [15:0] OSC_STARTUP_CYC = `OSC_STARTUP
) (
  input  wire logic        hclk,          // Bus clock.
  input  wire logic        hresetn,       // Asynchronous reset, active low.
  input  wire logic        hsel,          // Slave select.
  input  wire logic [11:0] haddr,         // Byte address.
  input  wire logic [1:0]  htrans,        // Transfer type.
  input  wire logic        hwrite,        // Write when high.
  input  wire logic [2:0]  hsize,         // Transfer size.
  input  wire logic [31:0] hwdata,        // Write data.
  input  wire logic        hready,        // Bus ready.
  input  wire logic        osc_stable,    // Oscillator start-up pulse level.
  output logic [31:0]      hrdata,        // Read data.
  output logic             hreadyout,     // Slave ready.
  output logic             hresp,         // Always OKAY.
  output logic [1:0]       clk_sel,       // Selected source to divider.
  output logic [1:0]       bus_div,       // Divider code in effect.
  output logic [3:0]       div_ratio,     // Divide ratio 1,2,4,8.
  output logic             osc_range_hi,  // High frequency range.
  output logic             osc_high_gain, // High gain operation.
  output logic             osc_request,   // Crystal requested.
  output logic             ext_ref_on,    // External reference enabled.
  output logic             aux_external_reference_clock, // Aux clock gate.
  output logic             loop_enable,   // Frequency-locked loop on.
  output logic [8:0]       period_trim,   // Internal period control.
  output logic             irq            // Interrupt, active high.
);

  logic [7:0]  ctrl1_ff;
  logic [7:0]  bus_divider_osc_control_ff;
  logic [7:0]  reference_trim_ff;
  logic        fine_trim_bit_ff;
  logic        oscillator_ready_ff;
  logic [1:0]  clock_mode_status_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;
  logic [1:0]  debug_ff;
  logic        prior_ext_ff;
  logic [3:0]  sync_cnt_ff;
  logic [1:0]  pend_mode_ff;
  logic [15:0] osc_cnt_ff;
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic        rd_pend_ff;
  logic [11:0] rd_addr_ff;

  logic        addr_ok;
  logic        wr_go;
  logic [7:0]  wbyte;
  logic        wr_div;
  logic        wr_ctrl1;
  logic        osc_in_use;
  logic        ext_mode;
  logic        bypass;
  logic        stop_mode;
  logic        debug_active;
  logic        mode_event;
  logic        osc_event;
  logic [7:0]  status_byte;
  logic [7:0]  rd_val;
  logic [1:0]  nxt_mode;

  assign addr_ok  = hsel && hready && htrans[1];
  assign wr_go    = wr_pend_ff;
  assign wbyte    = hwdata[7:0];
  assign wr_div   = wr_go && (wr_addr_ff == `OFF_DIV_OSC);
  assign wr_ctrl1 = wr_go && (wr_addr_ff == `OFF_CTRL1);
  assign stop_mode = debug_ff[`STOP_BIT];
  assign debug_active = debug_ff[`DEBUG_ON_BIT];

  // Reserved source code behaves as loop output.
  always_comb begin
    case (ctrl1_ff[`SOURCE_HI:`SOURCE_LO])
      2'b01:   nxt_mode = MODE_INT;
      2'b10:   nxt_mode = MODE_EXT;
      default: nxt_mode = MODE_LOOP;
    endcase
  end

  assign ext_mode = (clock_mode_status_ff == MODE_EXT);
  assign bypass   = (clock_mode_status_ff != MODE_LOOP);
  assign osc_in_use = bus_divider_osc_control_ff[`REF_TYPE_BIT] &&
                      (bus_divider_osc_control_ff[`EXT_ENABLE_BIT] ||
                       ext_mode);
  assign status_byte = {4'h0, clock_mode_status_ff, oscillator_ready_ff,
                        fine_trim_bit_ff};
  assign mode_event = (sync_cnt_ff == 4'h1);
  assign osc_event  = osc_in_use && !oscillator_ready_ff &&
                      (osc_cnt_ff == OSC_STARTUP_CYC);

  // Bus address phase is captured; writes land in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rd_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      rd_pend_ff <= addr_ok && !hwrite;
      wr_addr_ff <= haddr;
      rd_addr_ff <= haddr;
    end
  end

  always_comb begin
    case (rd_addr_ff)
      `OFF_CTRL1:    rd_val = ctrl1_ff;
      `OFF_DIV_OSC:  rd_val = bus_divider_osc_control_ff;
      `OFF_TRIM:     rd_val = reference_trim_ff;
      `OFF_STATUS:   rd_val = status_byte;
      `OFF_IRQ_STAT: rd_val = {6'h00, irq_stat_ff};
      `OFF_IRQ_MASK: rd_val = {6'h00, irq_mask_ff};
      `OFF_DEBUG:    rd_val = {6'h00, debug_ff};
      default:       rd_val = 8'h00;
    endcase
  end

  // Read data is registered so hrdata comes from a flop one cycle late.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(addr_ok && !hwrite);
      hresp     <= 1'b0;
      if (rd_pend_ff) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_ff                   <= `CTRL1_RST;
      bus_divider_osc_control_ff <= `DIV_OSC_RST;
      reference_trim_ff          <= `TRIM_RST;
      fine_trim_bit_ff           <= 1'b0;
      irq_mask_ff                <= 2'b00;
      debug_ff                   <= 2'b00;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_ff <= wbyte;
      end
      if (wr_div) begin
        bus_divider_osc_control_ff <= wbyte;
      end
      if (wr_go && wr_addr_ff == `OFF_TRIM) begin
        reference_trim_ff <= wbyte;
      end
      if (wr_go && wr_addr_ff == `OFF_STATUS) begin
        fine_trim_bit_ff <= wbyte[`FINE_BIT];
      end
      if (wr_go && wr_addr_ff == `OFF_IRQ_MASK) begin
        irq_mask_ff <= wbyte[1:0];
      end
      if (wr_go && wr_addr_ff == `OFF_DEBUG) begin
        debug_ff <= wbyte[1:0];
      end
    end
  end

  // Status follows the source only after a synchronization delay.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_cnt_ff          <= 4'h0;
      pend_mode_ff         <= MODE_LOOP;
      clock_mode_status_ff <= MODE_LOOP;
      clk_sel              <= MODE_LOOP;
    end else begin
      if (wr_ctrl1) begin
        sync_cnt_ff <= `SYNC_CYCLES;
      end else if (sync_cnt_ff != 4'h0) begin
        sync_cnt_ff <= sync_cnt_ff - 4'h1;
      end
      pend_mode_ff <= nxt_mode;
      if (mode_event) begin
        clock_mode_status_ff <= pend_mode_ff;
        clk_sel              <= pend_mode_ff;
      end
    end
  end

  // Stop-mode reference retention remembers whether external was in use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prior_ext_ff <= 1'b0;
    end else if (!stop_mode) begin
      prior_ext_ff <= ext_mode || (clock_mode_status_ff == MODE_LOOP &&
                      !ctrl1_ff[`INT_REF_BIT]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_ff          <= 16'h0000;
      oscillator_ready_ff <= 1'b0;
    end else begin
      if (!osc_in_use || oscillator_ready_ff) begin
        osc_cnt_ff <= 16'h0000;
      end else if (osc_stable && osc_cnt_ff != OSC_STARTUP_CYC) begin
        osc_cnt_ff <= osc_cnt_ff + 16'h0001;
      end
      if (osc_event) begin
        oscillator_ready_ff <= 1'b1;
      end else if (wr_div && (!wbyte[`EXT_ENABLE_BIT] ||
                   !wbyte[`REF_TYPE_BIT])) begin
        oscillator_ready_ff <= 1'b0;
      end
    end
  end

  // Sticky events: a set in the same cycle as a clear wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= 2'b00;
      irq         <= 1'b0;
    end else begin
      irq_stat_ff[`IRQ_OSC_BIT] <= osc_event ||
        (irq_stat_ff[`IRQ_OSC_BIT] &&
         !(wr_go && wr_addr_ff == `OFF_IRQ_STAT && wbyte[`IRQ_OSC_BIT]));
      irq_stat_ff[`IRQ_MODE_BIT] <= mode_event ||
        (irq_stat_ff[`IRQ_MODE_BIT] &&
         !(wr_go && wr_addr_ff == `OFF_IRQ_STAT && wbyte[`IRQ_MODE_BIT]));
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_div       <= 2'b01;
      div_ratio     <= 4'h2;
      osc_range_hi  <= 1'b0;
      osc_high_gain <= 1'b0;
      osc_request   <= 1'b0;
      ext_ref_on    <= 1'b0;
      aux_external_reference_clock <= 1'b0;
      loop_enable   <= 1'b1;
      period_trim   <= 9'h100;
    end else begin
      bus_div   <= bus_divider_osc_control_ff[`DIVIDER_HI:`DIVIDER_LO];
      div_ratio <= 4'h1 <<
                   bus_divider_osc_control_ff[`DIVIDER_HI:`DIVIDER_LO];
      osc_range_hi  <= bus_divider_osc_control_ff[`RANGE_BIT];
      osc_high_gain <= bus_divider_osc_control_ff[`GAIN_BIT];
      osc_request   <= bus_divider_osc_control_ff[`REF_TYPE_BIT];
      if (stop_mode) begin
        ext_ref_on <= bus_divider_osc_control_ff[`EXT_STOP_BIT] &&
                      (bus_divider_osc_control_ff[`EXT_ENABLE_BIT] ||
                       prior_ext_ff);
        aux_external_reference_clock <=
          bus_divider_osc_control_ff[`EXT_STOP_BIT] &&
          bus_divider_osc_control_ff[`EXT_ENABLE_BIT];
        loop_enable <= 1'b0;
      end else begin
        ext_ref_on <= bus_divider_osc_control_ff[`EXT_ENABLE_BIT] ||
                      ext_mode || !ctrl1_ff[`INT_REF_BIT];
        aux_external_reference_clock <=
          bus_divider_osc_control_ff[`EXT_ENABLE_BIT];
        loop_enable <= !(bypass &&
                         bus_divider_osc_control_ff[`LOW_POWER_BIT] &&
                         !debug_active);
      end
      // Coarse trim weighted above the fine step; bigger means longer.
      period_trim <= {reference_trim_ff, fine_trim_bit_ff};
    end
  end

endmodule

// ---- src/clk_src_defs.svh ----
// Register offsets, field positions, reset values and timing constants.
`ifndef CLK_SRC_DEFS_SVH
`define CLK_SRC_DEFS_SVH
`define OFF_CTRL1      12'h000
`define OFF_DIV_OSC    12'h004
`define OFF_TRIM       12'h008
`define OFF_STATUS     12'h00c
`define OFF_IRQ_STAT   12'h010
`define OFF_IRQ_MASK   12'h014
`define OFF_DEBUG      12'h018
`define CTRL1_RST      8'h00
`define DIV_OSC_RST    8'h40
`define TRIM_RST       8'h80
`define DIVIDER_HI     7
`define DIVIDER_LO     6
`define RANGE_BIT      5
`define GAIN_BIT       4
`define LOW_POWER_BIT  3
`define REF_TYPE_BIT   2
`define EXT_ENABLE_BIT 1
`define EXT_STOP_BIT   0
`define SOURCE_HI      7
`define SOURCE_LO      6
`define INT_REF_BIT    2
`define FINE_BIT       0
`define STOP_BIT       1
`define DEBUG_ON_BIT   0
`define IRQ_OSC_BIT    0
`define IRQ_MODE_BIT   1
`define SYNC_CYCLES    4'h4
`define OSC_STARTUP    16'h1000
`endif

// ---- src/clk_src_pkg.sv ----
// Types shared by the clock source control block.
package clk_src_pkg;
  typedef enum logic [1:0] {
    MODE_LOOP = 2'b00,
    MODE_INT  = 2'b01,
    MODE_EXT  = 2'b10,
    MODE_RSV  = 2'b11
  } clk_mode_e;
endpackage

// ---- tb/ext_osc_model.sv ----
// Behavioural external crystal oscillator with a start-up delay.
module ext_osc_model #(
  parameter int START = 6  // Cycles until the crystal is stable.
) (
  input  wire logic hclk,      // Bus clock.
  input  wire logic hresetn,   // Asynchronous reset, active low.
  input  wire logic run,       // Crystal requested and reference enabled.
  output logic      osc_stable // High once the crystal runs.
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Dropping the request restarts the start-up count from zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      osc_stable <= 1'b0;
    end else if (!run) begin
      cnt <= 0;
      osc_stable <= 1'b0;
    end else if (cnt < START) begin
      cnt <= cnt + 1;
    end else begin
      osc_stable <= 1'b1;
    end
  end
endmodule

// ---- tb/clock_source_ctrl_trim_status_asserts.sv ----
// Concurrent checks on the ports of the clock source control block.
`include "clk_src_defs.svh"
module clock_source_ctrl_trim_status_asserts (
  input wire logic        hclk,        // Bus clock.
  input wire logic        hresetn,     // Reset, active low.
  input wire logic        hsel,        // Slave select.
  input wire logic [11:0] haddr,       // Byte address.
  input wire logic [1:0]  htrans,      // Transfer type.
  input wire logic        hwrite,      // Write when high.
  input wire logic [31:0] hwdata,      // Write data.
  input wire logic        hready,      // Bus ready.
  input wire logic [31:0] hrdata,      // Read data.
  input wire logic        hreadyout,   // Slave ready.
  input wire logic [1:0]  clk_sel,     // Source in effect.
  input wire logic [1:0]  bus_div,     // Divider code.
  input wire logic [3:0]  div_ratio,   // Divide ratio.
  input wire logic        osc_range_hi,  // High range.
  input wire logic        osc_high_gain, // High gain.
  input wire logic        osc_request,   // Crystal requested.
  input wire logic        aux_external_reference_clock, // Aux gate.
  input wire logic        loop_enable, // Loop on.
  input wire logic [8:0]  period_trim  // Period control.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wv_ff;
  logic        rv_ff;
  logic [11:0] wa_ff;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_ff <= 1'b0;
      rv_ff <= 1'b0;
      wa_ff <= 12'h000;
    end else begin
      wv_ff <= hsel && hready && htrans[1] && hwrite;
      rv_ff <= hsel && hready && htrans[1] && !hwrite &&
               haddr == `OFF_STATUS;
      wa_ff <= haddr;
    end
  end

  property p_ratio; div_ratio == (4'h1 << bus_div); endproperty
  a_ratio: assert property (p_ratio) else $error("bad ratio");
  property p_rst;
    $rose(hresetn) |-> bus_div == 2'b01 && loop_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_bus_divider_field;
    wv_ff && wa_ff == `OFF_DIV_OSC |-> ##2 bus_div == $past(hwdata[7:6], 2);
  endproperty
  a_bus_divider_field: assert property (p_bus_divider_field) else $error("bad divider");
  property p_osc;
    wv_ff && wa_ff == `OFF_DIV_OSC |-> ##2 {osc_range_hi, osc_high_gain,
      osc_request} == $past({hwdata[5:4], hwdata[2]}, 2);
  endproperty
  a_osc: assert property (p_osc) else $error("bad osc");
  property p_aux;
    wv_ff && wa_ff == `OFF_DIV_OSC && !hwdata[1] |-> ##2
      !aux_external_reference_clock;
  endproperty
  a_aux: assert property (p_aux) else $error("aux on");
  property p_trim;
    wv_ff && wa_ff == `OFF_TRIM |-> ##2 period_trim[8:1] == $past(hwdata[7:0], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("bad trim");
  property p_fine_trim_bit;
    wv_ff && wa_ff == `OFF_STATUS |-> ##2 period_trim[0] == $past(hwdata[0], 2);
  endproperty
  a_fine_trim_bit: assert property (p_fine_trim_bit) else $error("bad fine");
  property p_stat;
    rv_ff |=> hreadyout && hrdata[7:4] == 4'h0 &&
      hrdata[3:2] == $past(clk_sel);
  endproperty
  a_stat: assert property (p_stat) else $error("bad status");
  property p_sync;
    wv_ff && wa_ff == `OFF_CTRL1 |=> $stable(clk_sel) [*2];
  endproperty
  a_sync: assert property (p_sync) else $error("early mode");
  property p_loop; !loop_enable |-> clk_sel != 2'b00; endproperty
  a_loop: assert property (p_loop) else $error("loop off");
  c_stat: cover property (rv_ff);
  c_lp: cover property (!loop_enable);
  c_mode: cover property (wv_ff && wa_ff == `OFF_CTRL1);
endmodule

bind clock_source_ctrl_trim_status clock_source_ctrl_trim_status_asserts
  clock_source_ctrl_trim_status_asserts_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .clk_sel(clk_sel), .bus_div(bus_div),
  .div_ratio(div_ratio), .osc_range_hi(osc_range_hi),
  .osc_high_gain(osc_high_gain), .osc_request(osc_request),
  .aux_external_reference_clock(aux_external_reference_clock),
  .loop_enable(loop_enable), .period_trim(period_trim));

// ---- tb/clock_source_ctrl_trim_status_tb_top.sv ----
// Self-checking bench for the clock source control block.
`include "clk_src_defs.svh"
module clock_source_ctrl_trim_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0, clk_sel, bus_div;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, q;
  logic [3:0]  div_ratio;
  logic [8:0]  period_trim;
  logic        hreadyout, hresp, osc_stable, irq, osc_range_hi;
  logic        osc_high_gain, osc_request, ext_ref_on, loop_enable;
  logic        aux_external_reference_clock;
  wire         hready = hreadyout;
  int          fails = 0, checked = 0;

  clock_source_ctrl_trim_status #(.OSC_STARTUP_CYC(16'h0008))
    clock_source_ctrl_trim_status_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .osc_stable, .hrdata,
    .hreadyout, .hresp, .clk_sel, .bus_div, .div_ratio, .osc_range_hi,
    .osc_high_gain, .osc_request, .ext_ref_on, .loop_enable, .irq,
    .aux_external_reference_clock, .period_trim);
  ext_osc_model ext_osc_model_inst (.hclk, .hresetn, .osc_stable,
    .run(osc_request && ext_ref_on));

  initial begin
    forever #4 hclk = ~hclk;
  end

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Samples ready mid-cycle so the edge update never races the bench.
  task automatic wt();
    logic ok;
    ok = 1'b0;
    for (int n = 0; !ok; n++) begin
      @(negedge hclk);
      ok = (hready === 1'b1);
      q = hrdata;
      @(posedge hclk);
      if (n > 50) begin
        fails++;
        summarize();
      end
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wt();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wt();
  endtask

  // Outputs follow one edge after the register, so let two edges pass.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(negedge hclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] m, e);
    for (int n = 0; n < 40; n++) begin
      xfer(1'b0, a, 8'h00);
      if ((q & m) === e) break;
    end
    chk(q & m, e);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({bus_div, div_ratio, loop_enable, period_trim},
        {2'b01, 4'h2, 1'b1, `TRIM_RST, 1'b0});
    rd(`OFF_DIV_OSC, `DIV_OSC_RST);
    rd(`OFF_TRIM, `TRIM_RST);
    rd(`OFF_STATUS, 32'h0);
    wr(12'h01c, 8'hff);
    rd(12'h01c, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`OFF_DIV_OSC, 8'(c << 6));
      chk({bus_div, div_ratio}, {c[1:0], 4'(1 << c)});
    end
    wr(`OFF_IRQ_MASK, 8'h01);
    wr(`OFF_DIV_OSC, 8'h36);
    chk({osc_range_hi, osc_high_gain, osc_request,
         aux_external_reference_clock}, 4'hf);
    poll(`OFF_STATUS, 32'h2, 32'h2);
    chk(irq, 1'b1);
    wr(`OFF_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    wr(`OFF_IRQ_MASK, 8'h01);
    wr(`OFF_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    wr(`OFF_DIV_OSC, 8'h26);
    chk(osc_high_gain, 1'b0);
    rd(`OFF_STATUS, 32'h2);
    wr(`OFF_DIV_OSC, 8'h32);
    rd(`OFF_STATUS, 32'h0);
    wr(`OFF_DIV_OSC, 8'h04);
    chk(aux_external_reference_clock, 1'b0);
    wr(`OFF_TRIM, 8'ha5);
    wr(`OFF_STATUS, 8'hff);
    chk(period_trim, {8'ha5, 1'b1});
    rd(`OFF_STATUS, 32'h1);
    wr(`OFF_CTRL1, 8'h44);
    chk(clk_sel, 2'b00);
    poll(`OFF_STATUS, 32'hc, 32'h4);
    wr(`OFF_DIV_OSC, 8'h08);
    chk(loop_enable, 1'b0);
    wr(`OFF_DEBUG, 8'h01);
    chk(loop_enable, 1'b1);
    wr(`OFF_DEBUG, 8'h02);
    wr(`OFF_DIV_OSC, 8'h03);
    chk(ext_ref_on, 1'b1);
    wr(`OFF_DIV_OSC, 8'h02);
    chk(ext_ref_on, 1'b0);
    summarize();
  end
endmodule
